// [verilog/iop_port_map.vh]
// register map, field layout and reset values of the i/o port unit
`ifndef IOP_PORT_MAP_VH
`define IOP_PORT_MAP_VH

// ----------------------------------------------------------------
// address regions, selected by paddr[11:10]
// ----------------------------------------------------------------
`define IOP_RGN_HI      11
`define IOP_RGN_LO      10
`define IOP_RGN_PORT    2'h0
`define IOP_RGN_CB      2'h1
`define IOP_RGN_IRQ     2'h2
`define IOP_SEL_HI      9
`define IOP_SEL_LO      6
`define IOP_IDX_HI      5
`define IOP_IDX_LO      2

// ----------------------------------------------------------------
// per-port registers, word index in paddr[5:2]
// ----------------------------------------------------------------
`define IOP_REG_CTRL    4'h0
`define IOP_REG_DATA    4'h1
`define IOP_REG_COND    4'h2
`define IOP_REG_TIME    4'h3
`define IOP_REG_COUNT   4'h4
`define IOP_REG_STAMP   4'h5

// ----------------------------------------------------------------
// port control fields
// ----------------------------------------------------------------
`define IOP_CTRL_W      11
`define IOP_CTRL_RST    11'h000
`define IOP_C_EN        0
`define IOP_C_OUT       1
`define IOP_C_OD        2
`define IOP_C_CM_LO     3
`define IOP_C_CM_HI     4
`define IOP_C_STB       5
`define IOP_C_TIMED     6
`define IOP_C_FULL      7
`define IOP_C_CB_LO     8
`define IOP_C_CB_HI     10
`define IOP_CM_NONE     2'h0
`define IOP_CM_EQ       2'h1
`define IOP_CM_NEQ      2'h2

// ----------------------------------------------------------------
// clock block config: divide in [7:0], source select in [8]
// ----------------------------------------------------------------
`define IOP_CB_W        9
`define IOP_CB_RST      9'h000
`define IOP_CB_SRC      8
`define IOP_CB_DIV_HI   7

// ----------------------------------------------------------------
// interrupt registers, word index in paddr[5:2]
// ----------------------------------------------------------------
`define IOP_IRQ_STATUS  4'h0
`define IOP_IRQ_MASK    4'h1

`endif

// [verilog/iop_port_unit.v]
// i/o port unit: five ports, pin precedence mux, clock blocks, apb registers
`include "iop_port_map.vh"

// Summary of operation
// - ports one, four, eight, sixteen and thirty-two pins wide
// - all pins of one port share one direction
// - drive pins or sample them, optionally waiting for a pin condition
// - every register access completes in one cycle, no wait states
// - open-drain: zero pulls the pin low, one releases it
// - output data passes through transfer register and pin register; input pins are captured straight into the transfer register
// - 16-bit counter per port can schedule the transfer
// - port counter readable at any time
// - each transfer captures the counter as timestamp
// - enabled link disables port drive on its pins
// - enabled narrower port overrules wider ports on shared pins
// - unshared pins of a wider port stay with that port
// - a port always transfers its full width
// - six clock blocks; block zero is the reference clock
// - clock block may count edges of the 1-bit port pin, divided
// - input strobe gates sampling; output strobe marks sent data
// - after reset every port uses clock block zero
// - pin events are signalled straight to the tile
module iop_port_unit #(
    parameter NP        = 5,                 // number of ports
    parameter NPIN      = 32,                // number of pins
    parameter NCB       = 6,                 // number of clock blocks
    parameter CW        = 16,                // port counter width
    parameter LINK_PINS = 32'h0000_0000      // pins taken by the link
) (
    input  wire            i_ref_clk,               // reference clock
    input  wire            i_rst_b,                 // async reset, low
    input  wire            i_psel,                  // apb select
    input  wire            i_penable,               // apb enable
    input  wire            i_pwrite,                // apb direction
    input  wire [11:0]     i_paddr,                 // apb byte address
    input  wire [31:0]     i_pwdata,                // apb write data
    output reg  [31:0]     o_prdata,                // apb read data
    output wire            o_pready,                // apb ready
    output wire            o_pslverr,               // apb error
    input  wire            i_link_en,               // link owns its pins
    input  wire [NPIN-1:0] i_pin_in,                // pin levels
    output reg  [NPIN-1:0] o_pin_out,               // pin drive value
    output reg  [NPIN-1:0] o_pin_oe,                // pin drive enable
    input  wire [NP-1:0]   i_strobe_from_external,  // input strobes
    output wire [NP-1:0]   o_strobe_to_external,    // output strobes
    output wire [NP-1:0]   o_event,                 // per-port event pulse
    output wire            o_irq                    // level interrupt
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function [5:0] pw;
        input integer p;
        begin
            if (p == 0) pw = 6'h01;
            else pw = 6'h04 << (p - 1);
        end
    endfunction

    function [31:0] pmask;
        input integer p;
        begin
            if (pw(p) >= 6'h20) pmask = 32'hffff_ffff;
            else pmask = (32'h1 << pw(p)) - 32'h1;
        end
    endfunction

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire [1:0] rgn = i_paddr[`IOP_RGN_HI:`IOP_RGN_LO];
    wire [3:0] sel = i_paddr[`IOP_SEL_HI:`IOP_SEL_LO];
    wire [3:0] idx = i_paddr[`IOP_IDX_HI:`IOP_IDX_LO];
    wire       acc = i_psel & i_penable;
    wire       wr  = acc & i_pwrite;
    wire       rd  = acc & ~i_pwrite;
    reg        hit;
    reg        hit_port;
    reg        hit_cb;

    always @* begin
        hit_port = 1'b0;
        hit_cb   = 1'b0;
        if (rgn == `IOP_RGN_PORT) begin
            hit_port = (sel < NP) && (idx <= `IOP_REG_STAMP);
        end else if (rgn == `IOP_RGN_CB) begin
            hit_cb = (sel == 4'h0) && (idx < NCB) && (idx != 4'h0);
        end
        hit = hit_port | hit_cb |
              ((rgn == `IOP_RGN_IRQ) && (sel == 4'h0) && (idx <= `IOP_IRQ_MASK));
    end

    assign o_pready  = 1'b1;
    assign o_pslverr = acc & ~hit;

    // ------------------------------------------------------------
    // clock blocks
    // ------------------------------------------------------------
    reg            pin0_prev_q;
    wire [NCB-1:0] cb_tick;
    wire [NCB*`IOP_CB_W-1:0] cb_cfg_f;

    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) pin0_prev_q <= 1'b0;
        else pin0_prev_q <= i_pin_in[0];
    end

    assign cb_tick[0] = 1'b1;
    assign cb_cfg_f[`IOP_CB_W-1:0] = `IOP_CB_RST;

    genvar k;
    generate
        for (k = 1; k < NCB; k = k + 1) begin : g_cb
            reg [`IOP_CB_W-1:0]     cfg_q;
            reg [`IOP_CB_DIV_HI:0]  div_q;
            reg                     tick_q;
            // external clock is the 1-bit port's pin, seen as a rising edge
            wire src_ev = cfg_q[`IOP_CB_SRC] ? (i_pin_in[0] & ~pin0_prev_q)
                                             : 1'b1;
            always @(posedge i_ref_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    cfg_q  <= `IOP_CB_RST;
                    div_q  <= 8'h00;
                    tick_q <= 1'b0;
                end else begin
                    if (wr && hit_cb && idx == k) begin
                        cfg_q <= i_pwdata[`IOP_CB_W-1:0];
                        div_q <= 8'h00;
                    end else if (src_ev) begin
                        if (div_q >= cfg_q[`IOP_CB_DIV_HI:0]) begin
                            div_q <= 8'h00;
                        end else begin
                            div_q <= div_q + 8'h01;
                        end
                    end
                    tick_q <= src_ev && (div_q >= cfg_q[`IOP_CB_DIV_HI:0]);
                end
            end
            assign cb_tick[k] = tick_q;
            assign cb_cfg_f[k*`IOP_CB_W +: `IOP_CB_W] = cfg_q;
        end
    endgenerate

    // ------------------------------------------------------------
    // ports
    // ------------------------------------------------------------
    wire [NP-1:0]    en_f;
    wire [NP-1:0]    dir_f;
    wire [NP-1:0]    od_f;
    wire [NP-1:0]    ev_f;
    wire [NP*32-1:0] pin_f;
    wire [NP*32-1:0] rword_f;

    genvar p;
    generate
        for (p = 0; p < NP; p = p + 1) begin : g_port
            localparam [31:0] M = pmask(p);
            reg [`IOP_CTRL_W-1:0] ctrl_q;
            reg [31:0]            xfer_q;
            reg [31:0]            pin_q;
            reg [31:0]            cond_q;
            reg [CW-1:0]          time_q;
            reg [CW-1:0]          cnt_q;
            reg [CW-1:0]          stamp_q;
            reg                   full_q;
            reg                   stb_q;
            reg                   ev_q;
            reg [31:0]            rw;
            wire [2:0] cbs  = ctrl_q[`IOP_C_CB_HI:`IOP_C_CB_LO];
            wire       tick = (cbs < NCB) ? cb_tick[cbs] : cb_tick[0];
            wire       pwr  = wr && hit_port && sel == p;
            wire       wdat = pwr && idx == `IOP_REG_DATA;
            wire       rdat = rd && hit_port && sel == p && idx == `IOP_REG_DATA;
            wire [1:0] cm   = ctrl_q[`IOP_C_CM_HI:`IOP_C_CM_LO];
            wire       eq   = ((i_pin_in & M) == (cond_q & M));
            wire       cok  = (cm == `IOP_CM_EQ)  ? eq :
                              (cm == `IOP_CM_NEQ) ? ~eq : 1'b1;
            wire       go   = tick && ctrl_q[`IOP_C_EN] &&
                              (~ctrl_q[`IOP_C_TIMED] || cnt_q == time_q);
            wire       isout = ctrl_q[`IOP_C_OUT];
            wire       fo   = go && isout && full_q;
            wire       fi   = go && ~isout && ~full_q && cok &&
                              (~ctrl_q[`IOP_C_STB] || i_strobe_from_external[p]);

            always @(posedge i_ref_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    ctrl_q  <= `IOP_CTRL_RST;
                    xfer_q  <= 32'h0000_0000;
                    pin_q   <= 32'h0000_0000;
                    cond_q  <= 32'h0000_0000;
                    time_q  <= 16'h0000;
                    cnt_q   <= 16'h0000;
                    stamp_q <= 16'h0000;
                    full_q  <= 1'b0;
                    stb_q   <= 1'b0;
                    ev_q    <= 1'b0;
                end else begin
                    if (tick) cnt_q <= cnt_q + 16'h0001;
                    if (pwr && idx == `IOP_REG_CTRL) ctrl_q <= i_pwdata[`IOP_CTRL_W-1:0];
                    if (pwr && idx == `IOP_REG_COND) cond_q <= i_pwdata & M;
                    if (pwr && idx == `IOP_REG_TIME) time_q <= i_pwdata[CW-1:0];
                    if (fo) pin_q <= xfer_q;
                    if (fi) xfer_q <= i_pin_in & M;
                    else if (wdat && isout) xfer_q <= i_pwdata & M;
                    if (fo || fi) stamp_q <= cnt_q;
                    // new data or capture wins over a drain or read in the same cycle
                    full_q <= (full_q & ~fo & ~(rdat & ~isout)) | fi | (wdat & isout);
                    stb_q  <= fo & ctrl_q[`IOP_C_STB];
                    ev_q   <= fo | fi;
                end
            end

            always @* begin
                rw = 32'h0000_0000;
                if (idx == `IOP_REG_CTRL) begin
                    rw[`IOP_CTRL_W-1:0] = ctrl_q;
                    rw[`IOP_C_FULL] = full_q;
                end else if (idx == `IOP_REG_DATA) begin
                    rw = xfer_q;
                end else if (idx == `IOP_REG_COND) begin
                    rw = cond_q;
                end else if (idx == `IOP_REG_TIME) begin
                    rw[CW-1:0] = time_q;
                end else if (idx == `IOP_REG_COUNT) begin
                    rw[CW-1:0] = cnt_q;
                end else if (idx == `IOP_REG_STAMP) begin
                    rw[CW-1:0] = stamp_q;
                end
            end

            assign en_f[p]  = ctrl_q[`IOP_C_EN];
            assign dir_f[p] = isout;
            assign od_f[p]  = ctrl_q[`IOP_C_OD];
            assign ev_f[p]  = ev_q;
            assign pin_f[p*32 +: 32] = pin_q;
            assign rword_f[p*32 +: 32] = rw;
            assign o_strobe_to_external[p] = stb_q;
        end
    endgenerate

    assign o_event = ev_f;

    // ------------------------------------------------------------
    // pin precedence mux
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < NPIN; i = i + 1) begin : g_pin
            localparam [5:0] PI = i;
            reg     po;
            reg     oe;
            integer q;
            always @* begin
                po = 1'b0;
                oe = 1'b0;
                // walk wide to narrow so the narrowest enabled owner is last
                for (q = NP - 1; q >= 0; q = q - 1) begin
                    if (en_f[q] && pw(q) > PI) begin
                        if (!dir_f[q]) begin
                            po = 1'b0;
                            oe = 1'b0;
                        end else if (od_f[q]) begin
                            po = 1'b0;
                            oe = ~pin_f[q*32+i];
                        end else begin
                            po = pin_f[q*32+i];
                            oe = 1'b1;
                        end
                    end
                end
                if (i_link_en && LINK_PINS[i]) begin
                    po = 1'b0;
                    oe = 1'b0;
                end
            end
            always @(posedge i_ref_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    o_pin_out[i] <= 1'b0;
                    o_pin_oe[i]  <= 1'b0;
                end else begin
                    o_pin_out[i] <= po;
                    o_pin_oe[i]  <= oe;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // interrupts and read data
    // ------------------------------------------------------------
    reg [NP-1:0] st_q;
    reg [NP-1:0] mask_q;
    wire irq_wr = wr && rgn == `IOP_RGN_IRQ && sel == 4'h0;

    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q   <= {NP{1'b0}};
            mask_q <= {NP{1'b0}};
        end else begin
            // a new event beats a clearing write in the same cycle
            if (irq_wr && idx == `IOP_IRQ_STATUS) st_q <= (st_q & ~i_pwdata[NP-1:0]) | ev_f;
            else st_q <= st_q | ev_f;
            if (irq_wr && idx == `IOP_IRQ_MASK) mask_q <= i_pwdata[NP-1:0];
        end
    end

    assign o_irq = |(st_q & mask_q);

    // read data is latched in the setup cycle so it is stable in access
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            o_prdata <= 32'h0000_0000;
            if (hit_port) begin
                o_prdata <= rword_f[sel*32 +: 32];
            end else if (hit_cb) begin
                o_prdata[`IOP_CB_W-1:0] <= cb_cfg_f[idx*`IOP_CB_W +: `IOP_CB_W];
            end else if (rgn == `IOP_RGN_IRQ && sel == 4'h0 && idx == `IOP_IRQ_STATUS) begin
                o_prdata[NP-1:0] <= st_q;
            end else if (rgn == `IOP_RGN_IRQ && sel == 4'h0 && idx == `IOP_IRQ_MASK) begin
                o_prdata[NP-1:0] <= mask_q;
            end
        end
    end

endmodule // iop_port_unit

// [verification/iop_port_unit_properties.sv]
// port-level checker of the i/o port unit, bound to its top module
module iop_port_unit_properties #(
    parameter NPIN      = 32,
    parameter LINK_PINS = 32'h0000_0000
) (
    input wire logic            i_ref_clk,            // clock
    input wire logic            i_rst_b,              // reset, low
    input wire logic            i_psel,               // apb select
    input wire logic            i_penable,            // apb enable
    input wire logic            i_pwrite,             // apb direction
    input wire logic [11:0]     i_paddr,              // apb address
    input wire logic [31:0]     o_prdata,             // apb read data
    input wire logic            o_pready,             // apb ready
    input wire logic            o_pslverr,            // apb error
    input wire logic            i_link_en,            // link owns pins
    input wire logic [NPIN-1:0] o_pin_oe,             // pin enables
    input wire logic [4:0]      o_strobe_to_external, // out strobes
    input wire logic [4:0]      o_event,              // port events
    input wire logic            o_irq                 // interrupt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wr_q;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // irq may only drop one edge after a clearing or mask write
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
        if (!i_rst_b) wr_q <= 1'b0;
        else wr_q <= i_psel & i_penable & i_pwrite;
    sequence s_access;
        i_psel && i_penable;
    endsequence
    sequence s_link_held;
        i_link_en ##1 i_link_en;
    endsequence
    pready_high_a:
        assert property (o_pready) else $error("ready low");
    slverr_access_a:
        assert property (o_pslverr |-> s_access) else $error("error outside access");
    unmapped_err_a:
        assert property (s_access ##0 (i_paddr[11:10] == 2'h3 || i_paddr == 12'h400)
            |-> o_pslverr) else $error("unmapped access not refused");
    err_data_zero_a:
        assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0) else $error("error data");
    strobe_event_a:
        assert property ((o_strobe_to_external & ~o_event) == 5'h0) else $error("lone strobe");
    link_release_a:
        assert property (s_link_held |-> (o_pin_oe & LINK_PINS) == 0) else $error("link pin driven");
    irq_rise_a:
        assert property ($rose(o_irq) |-> $past(o_event) != 5'h0 || wr_q)
            else $error("irq without cause");
    irq_fall_a:
        assert property ($fell(o_irq) |-> wr_q) else $error("irq dropped without write");
endmodule // iop_port_unit_properties

bind iop_port_unit iop_port_unit_properties #(.NPIN(NPIN), .LINK_PINS(LINK_PINS))
    iop_port_unit_properties_inst (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_link_en(i_link_en), .o_pin_oe(o_pin_oe), .o_event(o_event),
    .o_strobe_to_external(o_strobe_to_external), .o_irq(o_irq));

// [verification/iop_pin_partner.sv]
// pin-side model: external hardware plus the pads' pull-downs
module iop_pin_partner (
    input  wire logic [31:0] i_pin_out, // device drive value
    input  wire logic [31:0] i_pin_oe,  // device drive enable
    input  wire logic [31:0] i_ext_val, // far-side drive value
    input  wire logic [31:0] i_ext_en,  // far-side drive enable
    output wire logic [31:0] o_pin_lvl  // resolved pin levels
);
    timeunit 1ns;
    timeprecision 1ns;
    // a released pin falls to the pull-down, it never keeps its last value
    assign o_pin_lvl = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_en & i_ext_val);
endmodule // iop_pin_partner

// [verification/iop_port_unit_tb_top.sv]
// self-checking bench of the i/o port unit
module iop_port_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, pready, pslverr, irq;
    logic        rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, link_en = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, ext_val = 32'h0, ext_en = 32'h0;
    logic [31:0] prdata, pin_out, pin_oe, pin_lvl;
    logic [4:0]  stb_in = 5'h0, stb_out, evt;
    int          n_mismatch = 0, total_checks = 0, cycles = 0;

    iop_port_unit #(.LINK_PINS(32'hf000_0000)) iop_port_unit_inst (.i_ref_clk(clk),
        .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_link_en(link_en), .i_pin_in(pin_lvl), .o_pin_out(pin_out),
        .o_pin_oe(pin_oe), .i_strobe_from_external(stb_in), .o_strobe_to_external(stb_out),
        .o_event(evt), .o_irq(irq));
    iop_pin_partner iop_pin_partner_inst (.i_pin_out(pin_out), .i_pin_oe(pin_oe),
        .i_ext_val(ext_val), .i_ext_en(ext_en), .o_pin_lvl(pin_lvl));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask
    // an idle cycle after each transfer keeps psel from two writes in one step
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        logic e;
        apb(a, 1'b0, 32'h0, d, e);
    endtask
    function automatic logic [11:0] ra(input int p, input int off);
        return 12'(p * 64 + off);
    endfunction
    task automatic wait_evt(input int p, output int n);
        n = 0;
        while (evt[p] !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic t_reset();
        logic [31:0] d;
        logic e;
        for (int p = 0; p < 5; p++) begin
            rd(ra(p, 0), d);
            chk(d, 32'h0);
        end
        apb(12'h400, 1'b0, 32'h0, d, e);
        chk({31'h0, e}, 32'h1);
        apb(12'hc00, 1'b1, 32'h1, d, e);
        chk({31'h0, e}, 32'h1);
    endtask
    task automatic t_timed();
        logic [31:0] c;
        logic [15:0] t;
        int n;
        wr(ra(1, 0), 32'h63);
        rd(ra(1, 'h10), c);
        t = c[15:0] + 16'h3c;
        wr(ra(1, 'hc), {16'h0, t});
        wr(ra(1, 4), 32'hffff_fff5);
        wait_evt(1, n);
        chk({30'h0, stb_out[1], evt[1]}, 32'h3);
        chk({31'h0, n > 20}, 32'h1);
        repeat (2) @(posedge clk);
        chk({pin_oe[3:0], pin_out[3:0]}, 32'hf5);
        rd(ra(1, 'h14), c);
        chk(c, {16'h0, t});
    endtask
    task automatic t_pins();
        wr(ra(0, 0), 32'h7);
        wr(ra(0, 4), 32'h0);
        repeat (3) @(posedge clk);
        chk({pin_oe[3:0], pin_out[3:0]}, 32'hf4);
        wr(ra(0, 4), 32'h1);
        repeat (3) @(posedge clk);
        chk({pin_oe[3:0], pin_lvl[0]}, 32'h1c);
        wr(ra(4, 0), 32'h3);
        wr(ra(4, 4), 32'hffff_ffff);
        repeat (3) @(posedge clk);
        chk(pin_oe, 32'hffff_fffe);
        link_en <= 1'b1;
        repeat (3) @(posedge clk);
        chk(pin_oe, 32'h0fff_fffe);
        link_en <= 1'b0;
        for (int p = 0; p < 5; p++) wr(ra(p, 0), 32'h0);
    endtask
    task automatic t_input();
        logic [31:0] d;
        int n;
        ext_en <= 32'h0000_ffff;
        ext_val <= 32'h0000_003c;
        wr(12'h800, 32'hffff_ffff);
        wr(ra(2, 8), 32'ha5);
        wr(ra(2, 0), 32'h9);
        repeat (8) @(posedge clk);
        rd(12'h800, d);
        chk(d, 32'h0);
        wr(ra(2, 0), 32'h29);
        ext_val <= 32'h0000_12a5;
        repeat (6) @(posedge clk);
        rd(12'h800, d);
        chk(d, 32'h0);
        stb_in <= 5'h04;
        wait_evt(2, n);
        rd(12'h800, d);
        chk({d[4:0], irq}, 32'h8);
        wr(12'h804, 32'h4);
        chk({31'h0, irq}, 32'h1);
        stb_in <= 5'h0;
        wr(ra(2, 0), 32'h0);
        rd(ra(2, 4), d);
        chk(d, 32'ha5);
        wr(12'h800, 32'h4);
        chk({31'h0, irq}, 32'h0);
    endtask
    // ticks over a 28-cycle gap: reference, divide by four, six pin edges by two
    task automatic t_count();
        logic [31:0] a, b;
        int exp[3] = '{28, 7, 3};
        wr(ra(3, 8), 32'hffff);
        wr(12'h404, 32'h3);
        wr(12'h408, 32'h101);
        for (int k = 0; k < 3; k++) begin
            wr(ra(3, 0), 32'h9 | (k << 8));
            ext_val <= 32'h0000_12a4;
            repeat (8) @(posedge clk);
            rd(ra(3, 'h10), a);
            for (int i = 0; i < 6; i++) begin
                ext_val[0] <= 1'b1;
                repeat (2) @(posedge clk);
                ext_val[0] <= 1'b0;
                repeat (2) @(posedge clk);
            end
            @(posedge clk);
            rd(ra(3, 'h10), b);
            chk({16'h0, b[15:0] - a[15:0]}, exp[k]);
        end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset();
        t_timed();
        t_pins();
        t_input();
        t_count();
        finish_test();
    end
endmodule // iop_port_unit_tb_top
